// ---- inc/rxfsc_pkg.sv ----
// Constants, register map and carrier types of the receive framer status/control bank
package rxfsc_pkg;

	localparam logic [8:0] OFS_INTERLEAVE = 9'h088;
	localparam logic [8:0] OFS_SPARE_LEN  = 9'h089;
	localparam logic [8:0] OFS_BERT_CTRL  = 9'h08A;
	localparam logic [8:0] OFS_SUPPRESS   = 9'h08B;
	localparam logic [8:0] OFS_ALARM_LS   = 9'h090;
	localparam logic [8:0] OFS_EVENT_LS   = 9'h091;
	localparam logic [8:0] OFS_CODE_LS    = 9'h092;

	localparam logic [7:0] REG_RESET      = 8'h00;
	localparam logic [7:0] MASK_INTERLEAVE = 8'h18;
	localparam logic [7:0] MASK_SPARE_LEN = 8'h07;
	localparam logic [7:0] MASK_BERT_CTRL = 8'h07;
	localparam logic [7:0] MASK_CODE_LS   = 8'hCC;
	localparam logic [7:0] MASK_E1_IRQ    = 8'h0F;

	localparam int IBO_SEL_BIT   = 4;
	localparam int IBO_EN_BIT    = 3;
	localparam int BERT_DIR_BIT  = 2;
	localparam int BERT_FUS_BIT  = 1;
	localparam int BERT_EN_BIT   = 0;

	// Condition order in the alarm vector: remote alarm, AIS, signal loss, frame loss
	localparam int COND_LOS      = 1;
	localparam int ALARM_CLR_LSB = 4;

	localparam int T1_ALIGNMENT_CHANGE_EVENT_BIT   = 5;
	localparam int T1_Z8_BIT     = 4;
	localparam int T1_Z16_BIT    = 3;
	localparam int T1_SEF_BIT    = 2;
	localparam int T1_B8ZS_BIT   = 1;
	localparam int T1_FBE_BIT    = 0;

	localparam int E1_CRC_BIT    = 6;
	localparam int E1_CAS_BIT    = 5;
	localparam int E1_FAS_BIT    = 4;
	localparam int E1_SA1_BIT    = 3;
	localparam int E1_SA0_BIT    = 2;
	localparam int E1_CMF_BIT    = 1;
	localparam int E1_AF_BIT     = 0;

	localparam int CODE_LORC_CLR = 7;
	localparam int CODE_SPARE_CLR = 6;
	localparam int CODE_LORC_DET = 3;
	localparam int CODE_SPARE_DET = 2;

	localparam logic [2:0] SPARE_LEN_DUAL = 3'h7;
	localparam logic [4:0] SPARE_LEN_LONG = 5'h08;

	localparam int LOS_ZERO_RUN   = 192;
	localparam int ZERO_RUN_SHORT = 8;
	localparam int ZERO_RUN_LONG  = 16;
	localparam int SEF_WINDOW     = 6;
	localparam int SEF_ERRORS     = 2;
	localparam int CRC_WINDOW     = 1000;
	localparam int CRC_ERRORS     = 915;
	localparam int CAS_ERR_RUN    = 2;
	localparam int FAS_ERR_RUN    = 3;
	localparam int TS16_FRAMES    = 16;
	localparam int SA1_ZERO_LIMIT = 3;
	localparam int AIS_ONES_RUN   = 1024;

	localparam int CLK_PERIOD_PS    = 5000;
	localparam int AF_PERIOD_NS     = 250000;
	localparam int AF_PERIOD_CYCLES = AF_PERIOD_NS * 1000 / CLK_PERIOD_PS;
	localparam int CMF_PERIOD_NS    = 2000000;
	localparam int CMF_PER_AF       = CMF_PERIOD_NS / AF_PERIOD_NS;

	typedef struct packed {
		logic bit_valid;
		logic bit_value;
	} rxfsc_line_t;

	typedef struct packed {
		logic remote_alarm;
		logic frame_loss;
		logic rx_clock_loss;
		logic spare_code_match;
	} rxfsc_cond_t;

	typedef struct packed {
		logic realign_moved;
		logic fbit_valid;
		logic fbit_error;
		logic b8zs_word;
	} rxfsc_t1_ev_t;

	typedef struct packed {
		logic       crc_word_valid;
		logic       crc_word_error;
		logic       cas_word_valid;
		logic       cas_word_error;
		logic       fas_word_valid;
		logic       fas_word_error;
		logic       ts16_valid;
		logic [7:0] ts16_data;
		logic       mf_start;
		logic       crc4_enabled;
		logic       crc_mf_boundary;
	} rxfsc_e1_ev_t;

	typedef struct packed {
		logic       bit_valid;
		logic       rx_data;
		logic       tx_data;
		logic       fbit_pos;
		logic [2:0] chan_bit;
	} rxfsc_bert_in_t;

endpackage

// ---- rtl/rxfsc_sticky.sv ----
// Sticky status bits with host write-one-to-clear
`timescale 1ns/10ps
module rxfsc_sticky #(
	parameter int W = 8
) (
	input  wire logic         i_clock,
	input  wire logic         i_rst,
	input  wire logic [W-1:0] i_set,
	input  wire logic [W-1:0] i_clear,
	output logic      [W-1:0] o_status
);

	logic [W-1:0] status_reg;

	if (W < 1) begin : g_bad_width
		$error("rxfsc_sticky needs W of at least 1");
	end

	// A set in the clearing cycle wins so no event is lost
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			status_reg <= '0;
		end else begin
			status_reg <= (status_reg & ~i_clear) | i_set;
		end
	end

	assign o_status = status_reg;

endmodule // rxfsc_sticky

// ---- rtl/rxfsc_top.sv ----
// Receive framer control registers, condition detectors and latched status bank
`timescale 1ns/10ps
module rxfsc_top #(
	parameter int AIS_RUN   = rxfsc_pkg::AIS_ONES_RUN,
	parameter int AF_CYCLES = rxfsc_pkg::AF_PERIOD_CYCLES
) (
	input  wire logic                     i_clock,
	input  wire logic                     i_rst,
	input  wire logic [8:0]               i_addr,
	input  wire logic [7:0]               i_wdata,
	input  wire logic                     i_wr,
	input  wire logic                     i_rd,
	output logic      [7:0]               o_rdata,
	input  wire logic                     i_t1_mode,
	input  wire rxfsc_pkg::rxfsc_line_t    i_line,
	input  wire rxfsc_pkg::rxfsc_cond_t    i_cond,
	input  wire rxfsc_pkg::rxfsc_t1_ev_t   i_t1_ev,
	input  wire rxfsc_pkg::rxfsc_e1_ev_t   i_e1_ev,
	input  wire rxfsc_pkg::rxfsc_bert_in_t i_bert,
	output logic                          o_bert_valid,
	output logic                          o_bert_data,
	output logic                          o_ibo_enable,
	output logic                          o_ibo_frame_mode,
	output logic      [4:0]               o_spare_len_bits,
	output logic                          o_spare_len_dual,
	output logic                          o_signal_loss,
	output logic                          o_ais,
	output logic                          o_alarm_irq_req,
	output logic                          o_event_irq_req,
	output logic                          o_code_irq_req
);

	if (AIS_RUN < 2 || AIS_RUN > 65535) begin : g_bad_ais
		$error("AIS_RUN must lie in 2..65535");
	end
	if (AF_CYCLES < 2 || AF_CYCLES > 65535) begin : g_bad_af
		$error("AF_CYCLES must lie in 2..65535");
	end

	// ---------------- Register port ----------------
	logic [7:0] interleave_reg;
	logic [7:0] spare_len_reg;
	logic [7:0] bert_ctrl_reg;
	logic [7:0] suppress_reg;
	logic [7:0] rdata_reg;
	logic [7:0] alarm_status;
	logic [7:0] event_status;
	logic [7:0] code_status;
	logic [7:0] alarm_clear;
	logic [7:0] event_clear;
	logic [7:0] code_clear;

	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			interleave_reg <= rxfsc_pkg::REG_RESET;
			spare_len_reg  <= rxfsc_pkg::REG_RESET;
			bert_ctrl_reg  <= rxfsc_pkg::REG_RESET;
			suppress_reg   <= rxfsc_pkg::REG_RESET;
		end else if (i_wr) begin
			case (i_addr)
				rxfsc_pkg::OFS_INTERLEAVE: interleave_reg <= i_wdata & rxfsc_pkg::MASK_INTERLEAVE;
				rxfsc_pkg::OFS_SPARE_LEN:  spare_len_reg  <= i_wdata & rxfsc_pkg::MASK_SPARE_LEN;
				rxfsc_pkg::OFS_BERT_CTRL:  bert_ctrl_reg  <= i_wdata & rxfsc_pkg::MASK_BERT_CTRL;
				rxfsc_pkg::OFS_SUPPRESS:   suppress_reg   <= i_wdata;
				default: begin
				end
			endcase
		end
	end

	// Latched registers clear by writing ones
	assign alarm_clear = (i_wr && i_addr == rxfsc_pkg::OFS_ALARM_LS) ? i_wdata : 8'h00;
	assign event_clear = (i_wr && i_addr == rxfsc_pkg::OFS_EVENT_LS) ? i_wdata : 8'h00;
	assign code_clear  = (i_wr && i_addr == rxfsc_pkg::OFS_CODE_LS) ? i_wdata : 8'h00;

	// Read data stands only in the cycle after the strobe; unmapped reads zero
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			rdata_reg <= 8'h00;
		end else if (i_rd) begin
			case (i_addr)
				rxfsc_pkg::OFS_INTERLEAVE: rdata_reg <= interleave_reg;
				rxfsc_pkg::OFS_SPARE_LEN:  rdata_reg <= spare_len_reg;
				rxfsc_pkg::OFS_BERT_CTRL:  rdata_reg <= bert_ctrl_reg;
				rxfsc_pkg::OFS_SUPPRESS:   rdata_reg <= suppress_reg;
				rxfsc_pkg::OFS_ALARM_LS:   rdata_reg <= alarm_status;
				rxfsc_pkg::OFS_EVENT_LS:   rdata_reg <= event_status;
				rxfsc_pkg::OFS_CODE_LS:    rdata_reg <= code_status & rxfsc_pkg::MASK_CODE_LS;
				default:                   rdata_reg <= 8'h00;
			endcase
		end else begin
			rdata_reg <= 8'h00;
		end
	end

	assign o_rdata = rdata_reg;

	// ---------------- Control outputs ----------------
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			o_ibo_enable     <= 1'b0;
			o_ibo_frame_mode <= 1'b0;
			o_spare_len_bits <= 5'h01;
			o_spare_len_dual <= 1'b0;
		end else begin
			o_ibo_frame_mode <= interleave_reg[rxfsc_pkg::IBO_SEL_BIT];
			o_ibo_enable     <= interleave_reg[rxfsc_pkg::IBO_EN_BIT];
			if (spare_len_reg[2:0] == rxfsc_pkg::SPARE_LEN_DUAL) begin
				o_spare_len_bits <= rxfsc_pkg::SPARE_LEN_LONG;
				o_spare_len_dual <= i_t1_mode;
			end else begin
				o_spare_len_bits <= {2'h0, spare_len_reg[2:0]} + 5'h01;
				o_spare_len_dual <= 1'b0;
			end
		end
	end

	// ---------------- BERT port ----------------
	logic bert_take;

	// The framing bit has no channel bit, so suppress does not apply to it
	always_comb begin
		bert_take = i_bert.bit_valid && bert_ctrl_reg[rxfsc_pkg::BERT_EN_BIT];
		if (i_bert.fbit_pos) begin
			if (i_t1_mode && !bert_ctrl_reg[rxfsc_pkg::BERT_FUS_BIT]) begin
				bert_take = 1'b0;
			end
		end else if (suppress_reg[i_bert.chan_bit]) begin
			bert_take = 1'b0;
		end
	end

	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			o_bert_valid <= 1'b0;
			o_bert_data  <= 1'b0;
		end else begin
			o_bert_valid <= bert_take;
			if (bert_take) begin
				o_bert_data <= bert_ctrl_reg[rxfsc_pkg::BERT_DIR_BIT] ?
					i_bert.tx_data : i_bert.rx_data;
			end
		end
	end

	// ---------------- Line run detectors ----------------
	logic [7:0]  zero_run_reg;
	logic [15:0] ones_run_reg;
	logic        line_zero;
	logic        line_one;

	assign line_zero = i_line.bit_valid && !i_line.bit_value;
	assign line_one  = i_line.bit_valid && i_line.bit_value;

	// Counters saturate so a long run keeps its condition without wrapping
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			zero_run_reg <= 8'h00;
		end else if (line_one) begin
			zero_run_reg <= 8'h00;
		end else if (line_zero && zero_run_reg < 8'(rxfsc_pkg::LOS_ZERO_RUN)) begin
			zero_run_reg <= zero_run_reg + 8'h01;
		end
	end

	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			ones_run_reg <= 16'h0000;
		end else if (line_zero) begin
			ones_run_reg <= 16'h0000;
		end else if (line_one && ones_run_reg < 16'(AIS_RUN)) begin
			ones_run_reg <= ones_run_reg + 16'h0001;
		end
	end

	assign o_signal_loss = (zero_run_reg == 8'(rxfsc_pkg::LOS_ZERO_RUN));
	assign o_ais         = (ones_run_reg == 16'(AIS_RUN));

	// ---------------- Alarm latched status ----------------
	logic [3:0] cond_now;
	logic [3:0] cond_prev_reg;
	logic [7:0] alarm_set;

	assign cond_now = {i_cond.remote_alarm, o_ais, o_signal_loss, i_cond.frame_loss};

	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			cond_prev_reg <= 4'h0;
		end else begin
			cond_prev_reg <= cond_now;
		end
	end

	assign alarm_set = {cond_prev_reg & ~cond_now, cond_now & ~cond_prev_reg};

	rxfsc_sticky #(.W(8)) u_alarm_ls (
		.i_clock  (i_clock),
		.i_rst    (i_rst),
		.i_set    (alarm_set),
		.i_clear  (alarm_clear),
		.o_status (alarm_status)
	);

	// ---------------- T1 event sources ----------------
	logic [5:0] sef_hist_reg;
	logic [5:0] sef_hist_next;
	logic [7:0] t1_set;

	assign sef_hist_next = {sef_hist_reg[4:0], i_t1_ev.fbit_error};

	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			sef_hist_reg <= 6'h00;
		end else if (i_t1_ev.fbit_valid) begin
			sef_hist_reg <= sef_hist_next;
		end
	end

	always_comb begin
		t1_set = 8'h00;
		t1_set[rxfsc_pkg::T1_ALIGNMENT_CHANGE_EVENT_BIT] = i_t1_ev.realign_moved;
		t1_set[rxfsc_pkg::T1_Z8_BIT]   = line_zero &&
			zero_run_reg == 8'(rxfsc_pkg::ZERO_RUN_SHORT - 1);
		t1_set[rxfsc_pkg::T1_Z16_BIT]  = line_zero &&
			zero_run_reg == 8'(rxfsc_pkg::ZERO_RUN_LONG - 1);
		t1_set[rxfsc_pkg::T1_SEF_BIT]  = i_t1_ev.fbit_valid &&
			$countones(sef_hist_next) >= rxfsc_pkg::SEF_ERRORS;
		t1_set[rxfsc_pkg::T1_B8ZS_BIT] = i_t1_ev.b8zs_word;
		t1_set[rxfsc_pkg::T1_FBE_BIT]  = i_t1_ev.fbit_valid && i_t1_ev.fbit_error;
	end

	// ---------------- E1 event sources ----------------
	logic [9:0] crc_words_reg;
	logic [9:0] crc_errs_reg;
	logic [9:0] crc_errs_next;
	logic       crc_window_end;
	logic [1:0] cas_run_reg;
	logic [1:0] fas_run_reg;
	logic [3:0] ts16_frame_reg;
	logic [3:0] ts16_index;
	logic [7:0] ts16_zeros_reg;
	logic [7:0] ts16_zeros_next;
	logic       ts16_window_end;
	logic [15:0] af_cnt_reg;
	logic [2:0] cmf_div_reg;
	logic       af_tick;
	logic [7:0] e1_set;

	assign crc_errs_next  = crc_errs_reg + {9'h000, i_e1_ev.crc_word_error};
	assign crc_window_end = i_e1_ev.crc_word_valid &&
		crc_words_reg == 10'(rxfsc_pkg::CRC_WINDOW - 1);

	// Judged over back-to-back blocks of 1000 words
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			crc_words_reg <= 10'h000;
			crc_errs_reg  <= 10'h000;
		end else if (crc_window_end) begin
			crc_words_reg <= 10'h000;
			crc_errs_reg  <= 10'h000;
		end else if (i_e1_ev.crc_word_valid) begin
			crc_words_reg <= crc_words_reg + 10'h001;
			crc_errs_reg  <= crc_errs_next;
		end
	end

	// Run counters restart after firing, so a long bad stretch fires repeatedly
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			cas_run_reg <= 2'h0;
		end else if (i_e1_ev.cas_word_valid) begin
			if (!i_e1_ev.cas_word_error || cas_run_reg == 2'(rxfsc_pkg::CAS_ERR_RUN - 1)) begin
				cas_run_reg <= 2'h0;
			end else begin
				cas_run_reg <= cas_run_reg + 2'h1;
			end
		end
	end

	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			fas_run_reg <= 2'h0;
		end else if (i_e1_ev.fas_word_valid) begin
			if (!i_e1_ev.fas_word_error || fas_run_reg == 2'(rxfsc_pkg::FAS_ERR_RUN - 1)) begin
				fas_run_reg <= 2'h0;
			end else begin
				fas_run_reg <= fas_run_reg + 2'h1;
			end
		end
	end

	// Slot 16 windows are aligned to the multiframe start
	assign ts16_index      = i_e1_ev.mf_start ? 4'h0 : ts16_frame_reg;
	assign ts16_zeros_next = ((ts16_index == 4'h0) ? 8'h00 : ts16_zeros_reg) +
		(8'h08 - 8'($countones(i_e1_ev.ts16_data)));
	assign ts16_window_end = i_e1_ev.ts16_valid &&
		ts16_index == 4'(rxfsc_pkg::TS16_FRAMES - 1);

	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			ts16_frame_reg <= 4'h0;
			ts16_zeros_reg <= 8'h00;
		end else if (i_e1_ev.ts16_valid) begin
			ts16_frame_reg <= ts16_index + 4'h1;
			ts16_zeros_reg <= ts16_zeros_next;
		end
	end

	// Free-running align-frame timer; eight ticks make the 2 ms fallback
	assign af_tick = (af_cnt_reg == 16'(AF_CYCLES - 1));

	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			af_cnt_reg  <= 16'h0000;
			cmf_div_reg <= 3'h0;
		end else if (af_tick) begin
			af_cnt_reg  <= 16'h0000;
			cmf_div_reg <= cmf_div_reg + 3'h1;
		end else begin
			af_cnt_reg  <= af_cnt_reg + 16'h0001;
		end
	end

	always_comb begin
		e1_set = 8'h00;
		e1_set[rxfsc_pkg::E1_CRC_BIT] = crc_window_end &&
			crc_errs_next >= 10'(rxfsc_pkg::CRC_ERRORS);
		e1_set[rxfsc_pkg::E1_CAS_BIT] = i_e1_ev.cas_word_valid && i_e1_ev.cas_word_error &&
			cas_run_reg == 2'(rxfsc_pkg::CAS_ERR_RUN - 1);
		e1_set[rxfsc_pkg::E1_FAS_BIT] = i_e1_ev.fas_word_valid && i_e1_ev.fas_word_error &&
			fas_run_reg == 2'(rxfsc_pkg::FAS_ERR_RUN - 1);
		e1_set[rxfsc_pkg::E1_SA1_BIT] = ts16_window_end &&
			ts16_zeros_next < 8'(rxfsc_pkg::SA1_ZERO_LIMIT);
		e1_set[rxfsc_pkg::E1_SA0_BIT] = ts16_window_end &&
			ts16_zeros_next == 8'(8 * rxfsc_pkg::TS16_FRAMES);
		e1_set[rxfsc_pkg::E1_CMF_BIT] = i_e1_ev.crc4_enabled ? i_e1_ev.crc_mf_boundary :
			(af_tick && cmf_div_reg == 3'(rxfsc_pkg::CMF_PER_AF - 1));
		e1_set[rxfsc_pkg::E1_AF_BIT]  = af_tick;
	end

	// One register serves both modes; the mode picks which sources feed it
	rxfsc_sticky #(.W(8)) u_event_ls (
		.i_clock  (i_clock),
		.i_rst    (i_rst),
		.i_set    (i_t1_mode ? t1_set : e1_set),
		.i_clear  (event_clear),
		.o_status (event_status)
	);

	// ---------------- Code latched status ----------------
	logic [1:0] code_prev_reg;
	logic [1:0] code_now;
	logic [7:0] code_set;

	assign code_now = {i_cond.rx_clock_loss, i_cond.spare_code_match};

	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			code_prev_reg <= 2'h0;
		end else begin
			code_prev_reg <= code_now;
		end
	end

	always_comb begin
		code_set = 8'h00;
		code_set[rxfsc_pkg::CODE_LORC_CLR]  = code_prev_reg[1] && !code_now[1];
		code_set[rxfsc_pkg::CODE_LORC_DET]  = !code_prev_reg[1] && code_now[1];
		code_set[rxfsc_pkg::CODE_SPARE_CLR] = i_t1_mode && code_prev_reg[0] && !code_now[0];
		code_set[rxfsc_pkg::CODE_SPARE_DET] = i_t1_mode && !code_prev_reg[0] && code_now[0];
	end

	rxfsc_sticky #(.W(8)) u_code_ls (
		.i_clock  (i_clock),
		.i_rst    (i_rst),
		.i_set    (code_set),
		.i_clear  (code_clear),
		.o_status (code_status)
	);

	// ---------------- Interrupt requests ----------------
	assign o_alarm_irq_req = |alarm_status;
	assign o_event_irq_req = !i_t1_mode && |(event_status & rxfsc_pkg::MASK_E1_IRQ);
	assign o_code_irq_req  = |(code_status & rxfsc_pkg::MASK_CODE_LS);

	// ---------------- Checks ----------------
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (i_rst);

	chk_los_zero_run: assert property (
		line_zero && zero_run_reg == 8'(rxfsc_pkg::LOS_ZERO_RUN - 1) |=> o_signal_loss ##1
		alarm_status[rxfsc_pkg::COND_LOS])
		else $error("signal loss not flagged after 192 zeros");

	chk_alarm_fall_latch: assert property (
		$fell(o_signal_loss) |=> alarm_status[rxfsc_pkg::ALARM_CLR_LSB + rxfsc_pkg::COND_LOS])
		else $error("signal loss clear bit not latched");

	chk_status_sticky: assert property (
		alarm_status[rxfsc_pkg::COND_LOS] && !alarm_clear[rxfsc_pkg::COND_LOS]
		|=> alarm_status[rxfsc_pkg::COND_LOS])
		else $error("latched bit dropped without host clear");

	chk_bert_off_idle: assert property (
		!bert_ctrl_reg[rxfsc_pkg::BERT_EN_BIT] |=> !o_bert_valid)
		else $error("BERT active while disabled");

	chk_bert_suppress: assert property (
		i_bert.bit_valid && !i_bert.fbit_pos && suppress_reg[i_bert.chan_bit] |=> !o_bert_valid)
		else $error("suppressed channel bit reached BERT");

	chk_bert_source: assert property (
		bert_take && bert_ctrl_reg[rxfsc_pkg::BERT_DIR_BIT] |=> o_bert_data == $past(i_bert.tx_data))
		else $error("BERT not taking transmit path data");

	chk_bert_fbit_skip: assert property (
		i_t1_mode && i_bert.fbit_pos && !bert_ctrl_reg[rxfsc_pkg::BERT_FUS_BIT] |=> !o_bert_valid)
		else $error("framed BERT took the framing bit");

	chk_zero_run_short: assert property (
		i_t1_mode && line_zero && zero_run_reg == 8'(rxfsc_pkg::ZERO_RUN_SHORT - 1)
		|=> event_status[rxfsc_pkg::T1_Z8_BIT])
		else $error("eight zero event missing");

	chk_fas_resync_run: assert property (
		!i_t1_mode && i_e1_ev.fas_word_valid && i_e1_ev.fas_word_error && fas_run_reg == 2'h2
		|=> event_status[rxfsc_pkg::E1_FAS_BIT])
		else $error("FAS resync event missing after three errors");

	chk_t1_event_no_irq: assert property (
		i_t1_mode |-> !o_event_irq_req)
		else $error("T1 event register raised an interrupt");

	chk_e1_irq_high_bits: assert property (
		!i_t1_mode && (event_status & rxfsc_pkg::MASK_E1_IRQ) == 8'h00 |-> !o_event_irq_req)
		else $error("E1 high event bits raised an interrupt");

	chk_interleave_mode: assert property (
		i_wr && i_addr == rxfsc_pkg::OFS_INTERLEAVE |=> ##1
		o_ibo_frame_mode == $past(i_wdata[rxfsc_pkg::IBO_SEL_BIT], 2))
		else $error("interleave mode did not follow write");

	chk_spare_len_code: assert property (
		spare_len_reg[2:0] != rxfsc_pkg::SPARE_LEN_DUAL |=>
		o_spare_len_bits == {2'h0, $past(spare_len_reg[2:0])} + 5'h01)
		else $error("spare code length not field plus one");

endmodule // rxfsc_top

// ---- verif/rxfsc_line_model.sv ----
// Line source model: runs of equal bits, idle shows the inverse
`timescale 1ns/10ps
module rxfsc_line_model (
	input  wire logic              i_clock,
	input  wire logic              i_start,
	input  wire logic              i_value,
	input  wire logic [8:0]        i_len,
	output rxfsc_pkg::rxfsc_line_t o_line,
	output logic                   o_busy
);
	logic [8:0] left_reg = '0;
	initial o_line = '0;
	initial o_busy = 1'b0;
	always @(posedge i_clock) begin
		if (i_start) begin
			left_reg <= i_len;
			o_busy   <= 1'b1;
		end else if (left_reg != 9'h000) begin
			o_line   <= '{1'b1, i_value};
			left_reg <= left_reg - 9'h001;
		end else begin
			// Stale bit hidden so a held level cannot pass for a run
			o_line   <= '{1'b0, ~i_value};
			o_busy   <= 1'b0;
		end
	end
endmodule // rxfsc_line_model

// ---- verif/testbench.sv ----
// Self-checking bench for the receive status and control bank
`timescale 1ns/10ps
module testbench;
	logic                      clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, t1 = 1'b1;
	logic [8:0]                addr = '0, len = '0;
	logic [7:0]                wdata = '0, rdata, d;
	rxfsc_pkg::rxfsc_cond_t    cond = '0;
	rxfsc_pkg::rxfsc_t1_ev_t   t1ev = '0;
	rxfsc_pkg::rxfsc_e1_ev_t   e1ev = '0;
	rxfsc_pkg::rxfsc_bert_in_t bert = '0;
	rxfsc_pkg::rxfsc_line_t    line;
	logic                      go = 1'b0, val = 1'b0, busy, bv, bd, ien, ifr, dual, los, ais;
	logic                      irq_a, irq_e, irq_c;
	logic [4:0]                slen;
	int                        miscompares = 0, tests_run = 0;
	localparam logic [8:0]     OFS [8] = '{9'h088, 9'h089, 9'h08A, 9'h08B, 9'h090, 9'h091,
		9'h092, 9'h0A0};
	always #2.5 clk = ~clk;
	rxfsc_line_model far (.i_clock(clk), .i_start(go), .i_value(val), .i_len(len),
		.o_line(line), .o_busy(busy));
	rxfsc_top #(.AIS_RUN(8), .AF_CYCLES(16)) dut (.i_clock(clk), .i_rst(rst), .i_addr(addr),
		.i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_t1_mode(t1),
		.i_line(line), .i_cond(cond), .i_t1_ev(t1ev), .i_e1_ev(e1ev), .i_bert(bert),
		.o_bert_valid(bv), .o_bert_data(bd), .o_ibo_enable(ien), .o_ibo_frame_mode(ifr),
		.o_spare_len_bits(slen), .o_spare_len_dual(dual), .o_signal_loss(los), .o_ais(ais),
		.o_alarm_irq_req(irq_a), .o_event_irq_req(irq_e), .o_code_irq_req(irq_c));
	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
		tests_run++;
		if (s !== e) begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic wr_reg(input logic [8:0] a, input logic [7:0] v);
		@(posedge clk);
		addr  <= a;
		wdata <= v;
		wr    <= 1'b1;
		@(posedge clk);
		wr    <= 1'b0;
	endtask
	task automatic rmchk(input string n, input logic [8:0] a, input logic [7:0] e,
		input logic [7:0] m);
		@(posedge clk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clk);
		rd   <= 1'b0;
		#1 d = rdata;
		chk(n, d & m, e);
	endtask
	task automatic rchk(input string n, input logic [8:0] a, input logic [7:0] e);
		rmchk(n, a, e, 8'hFF);
	endtask
	task automatic send(input logic v, input logic [8:0] n);
		int i;
		i = 0;
		@(posedge clk);
		val <= v;
		len <= n;
		go  <= 1'b1;
		@(posedge clk);
		go  <= 1'b0;
		#1;
		while (busy !== 1'b0 && i < 400) begin
			@(posedge clk);
			#1 i++;
		end
		// Detect bits trail the last line bit by two cycles
		repeat (2) @(posedge clk);
		#1;
		if (i >= 400) begin
			miscompares++;
			wrap_up();
		end
	endtask
	task automatic ev_pulse(input logic [3:0] t, input logic [17:0] e);
		@(posedge clk);
		t1ev <= t;
		e1ev <= e;
		@(posedge clk);
		t1ev <= '0;
		e1ev <= '0;
	endtask
	task automatic bert_case(input logic [7:0] c, input logic [2:0] ch, input logic r, t, f,
		input logic [7:0] e);
		wr_reg(9'h08A, c);
		@(posedge clk);
		bert <= '{1'b1, r, t, f, ch};
		@(posedge clk);
		bert.bit_valid <= 1'b0;
		#1 chk("bert", {6'h00, bv, bd}, e);
	endtask
	initial begin
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		foreach (OFS[k]) rchk("reset", OFS[k], 8'h00);
		for (int k = 0; k < 2; k++) begin
			wr_reg(9'h088, 8'h08 << k);
			@(posedge clk);
			#1 chk("ibo", {6'h00, ifr, ien}, 8'h01 << k);
		end
		wr_reg(9'h088, 8'hFF);
		rchk("interleave", 9'h088, 8'h18);
		for (int f = 0; f < 8; f++) begin
			wr_reg(9'h089, 8'hF8 | 8'(f));
			@(posedge clk);
			#1 chk("spare", {2'h0, dual, slen}, (f == 7) ? 8'h28 : 8'(f + 1));
		end
		$display("control test done");
		wr_reg(9'h08B, 8'h80);
		bert_case(8'h01, 3'h7, 1'b1, 1'b0, 1'b0, 8'h00);
		bert_case(8'h01, 3'h0, 1'b1, 1'b0, 1'b0, 8'h03);
		bert_case(8'h05, 3'h0, 1'b1, 1'b0, 1'b0, 8'h02);
		bert_case(8'h01, 3'h0, 1'b0, 1'b1, 1'b1, 8'h00);
		bert_case(8'h03, 3'h0, 1'b1, 1'b0, 1'b1, 8'h03);
		bert_case(8'h00, 3'h0, 1'b0, 1'b1, 1'b0, 8'h01);
		$display("bert test done");
		send(1'b0, 9'd191);
		chk("los", {7'h00, los}, 8'h00);
		send(1'b0, 9'd1);
		chk("los", {6'h00, irq_a, los}, 8'h03);
		rchk("t1_event", 9'h091, 8'h18);
		chk("event_irq", {7'h00, irq_e}, 8'h00);
		send(1'b1, 9'd7);
		chk("ais", {6'h00, ais, los}, 8'h00);
		send(1'b1, 9'd1);
		chk("ais", {7'h00, ais}, 8'h01);
		rchk("alarm", 9'h090, 8'h26);
		wr_reg(9'h090, 8'h06);
		rchk("alarm", 9'h090, 8'h20);
		@(posedge clk);
		cond <= 4'hF;
		rchk("code", 9'h092, 8'h0C);
		@(posedge clk);
		cond <= 4'h0;
		rchk("code", 9'h092, 8'hCC);
		rchk("alarm", 9'h090, 8'hB9);
		chk("code_irq", {7'h00, irq_c}, 8'h01);
		$display("line test done");
		wr_reg(9'h091, 8'hFF);
		ev_pulse(4'h6, '0);
		rchk("fbit", 9'h091, 8'h01);
		ev_pulse(4'h6, '0);
		rchk("fbit", 9'h091, 8'h05);
		wr_reg(9'h091, 8'hFF);
		ev_pulse(4'h9, '0);
		rchk("realign", 9'h091, 8'h22);
		@(posedge clk);
		t1 <= 1'b0;
		wr_reg(9'h091, 8'hFF);
		repeat (2) ev_pulse(4'h0, 18'h03000);
		// Bits 1:0 follow the free-running align timer, so they are masked here
		rmchk("fas", 9'h091, 8'h00, 8'hFC);
		ev_pulse(4'h0, 18'h03000);
		repeat (2) ev_pulse(4'h0, 18'h0C000);
		// One full align period so bit 0 is surely latched
		repeat (16) @(posedge clk);
		rmchk("fas_cas", 9'h091, 8'h30, 8'hFC);
		chk("align", {7'h00, d[0]}, 8'h01);
		chk("event_irq", {7'h00, irq_e}, 8'h01);
		wr_reg(9'h091, 8'hFF);
		for (int i = 0; i < 16; i++) ev_pulse(4'h0, (i == 0) ? 18'h00804 : 18'h00800);
		for (int i = 0; i < 16; i++) ev_pulse(4'h0, (i == 0) ? 18'h00FFC : 18'h00FF8);
		rmchk("ts16", 9'h091, 8'h0C, 8'hFC);
		repeat (1000) ev_pulse(4'h0, 18'h30000);
		rmchk("crc", 9'h091, 8'h4C, 8'hFC);
		$display("event test done");
		wrap_up();
	end
endmodule // testbench
